// File: core/acr_byte_reg.sv
/*
 * One 8-bit read/write coefficient byte with its own reset value.
 * Assumes write strobe and data are synchronous to clock.
 */
`timescale 1ns/100ps
module acr_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] q
);

    logic [7:0] q_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_ff <= RESET_VAL;
        end else if (wr_stb) begin
            q_ff <= wr_data;
        end
    end

    assign q = q_ff;

endmodule

// File: core/acr_coeff_regs.sv
/*
 * Filter coefficient register bank: de-emphasis, spatial attenuation
 * and left ADC high-pass coefficient bytes, plus the reserved range.
 * Assumes the control-bus slave delivers byte-wide read and write
 * strobes with a page-local address, synchronous to clock.
 */
// Contract
// (R1) Each coefficient is one signed 16-bit value; de-emphasis numerator 0 has only its low byte here
// (R2) Full signed span, never clamped
// (R3) Two 8-bit bytes, high and low; de-emphasis numerator 0 has only its low byte here
// (R4) De-emphasis bytes take their reset defaults
// (R5) Spatial attenuation resets to largest positive
// (R6) Left ADC high-pass bytes reset defaults
// (R7) Reserved range is read-only, reads zero
// (R8) Host never writes the reserved range
// (R9) Read returns last written or default
`timescale 1ns/100ps
module acr_coeff_regs (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    input  wire logic [acr_pkg::AW-1:0] addr,
    input  wire logic [acr_pkg::DW-1:0] wr_data,
    output logic      [acr_pkg::DW-1:0] rd_data,
    output logic                        rd_valid,
    output logic      [7:0]             rdeemph_num0_low,
    output logic      [15:0]            rdeemph_num1,
    output logic      [15:0]            rdeemph_den1,
    output logic      [15:0]            spatial_atten,
    output logic      [15:0]            ladc_hpf_num0,
    output logic      [15:0]            ladc_hpf_num1
);
    import acr_pkg::*;

    // ------------------------------------------------------------------
    // Decode and storage
    // ------------------------------------------------------------------
    localparam int NB = NREG - 1;

    logic [NB-1:0] hit;
    logic [DW-1:0] q [NB];
    wire           rsvd_hit;
    logic [DW-1:0] nxt_rd_data;
    logic [DW-1:0] rd_data_ff;
    logic          rd_valid_ff;

    assign rsvd_hit = (addr >= RSVD_FIRST) && (addr <= RSVD_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_byte
            assign hit[gi] = (addr == REG_OFS[gi]);
            acr_byte_reg #(
                .RESET_VAL (REG_RST[gi]) // R4 R5 R6
            ) u_byte (
                .clock   (clock),
                .rst     (rst),
                .wr_stb  (wr_en && hit[gi]), // R3
                .wr_data (wr_data),
                .q       (q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Reserved and unmapped addresses fall through to zero
    always_comb begin
        nxt_rd_data = RSVD_VALUE; // R7
        for (int i = 0; i < NB; i++) begin
            if (hit[i]) begin
                nxt_rd_data = q[i]; // R9
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_ff  <= RSVD_VALUE;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign rd_data  = rd_data_ff;
    assign rd_valid = rd_valid_ff;

    // ------------------------------------------------------------------
    // Coefficient words to the filter datapaths
    // ------------------------------------------------------------------
    // Plain concatenation: no saturation, the datapath sees every code
    assign rdeemph_num0_low = q[I_RDE_N0_LO];
    assign rdeemph_num1  = {q[I_RDE_N1_HI], q[I_RDE_N1_LO]}; // R1
    assign rdeemph_den1  = {q[I_RDE_D1_HI], q[I_RDE_D1_LO]}; // R1
    assign spatial_atten = {q[I_SPA_HI], q[I_SPA_LO]}; // R2
    assign ladc_hpf_num0 = {q[I_LHP_N0_HI], q[I_LHP_N0_LO]}; // R1
    assign ladc_hpf_num1 = {q[I_LHP_N1_HI], q[I_LHP_N1_LO]}; // R1

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wr_atten_hi;
        wr_en && addr == SPATIAL_ATTEN_HIGH;
    endsequence

    sequence s_rd_mapped;
        rd_en && (|hit);
    endsequence

    sequence s_rd_atten_hi;
        rd_en && addr == SPATIAL_ATTEN_HIGH;
    endsequence

    property p_signed_word;
        @(posedge clock) disable iff (rst)
        (rd_en && !wr_en && addr == SPATIAL_ATTEN_HIGH)
            |=> rd_data == spatial_atten[15:8];
    endproperty
    a_signed_word: assert property (p_signed_word) // R1
        else $error("word top byte differs from register readback");

    property p_no_clamp;
        @(posedge clock) disable iff (rst)
        s_wr_atten_hi |=> spatial_atten[15:8] == $past(wr_data);
    endproperty
    a_no_clamp: assert property (p_no_clamp) // R2
        else $error("attenuation high byte altered on write");

    property p_byte_pair;
        @(posedge clock) disable iff (rst)
        (wr_en && addr == LADC_HPF_NUM1_LOW)
            |=> ladc_hpf_num1[7:0] == $past(wr_data)
                && $stable(ladc_hpf_num1[15:8]);
    endproperty
    a_byte_pair: assert property (p_byte_pair) // R3
        else $error("low byte write did not land in low half only");

    property p_rdeemph_rst;
        @(posedge clock)
        $fell(rst) |-> rdeemph_num1[15:8] == 8'hF3
            && rdeemph_den1 == 16'h537E && rdeemph_num0_low == 8'h55;
    endproperty
    a_rdeemph_rst: assert property (p_rdeemph_rst) // R4
        else $error("de-emphasis reset defaults wrong");

    property p_spatial_rst;
        @(posedge clock)
        $fell(rst) |-> spatial_atten == 16'h7FFF;
    endproperty
    a_spatial_rst: assert property (p_spatial_rst) // R5
        else $error("attenuation reset default wrong");

    property p_ladc_rst;
        @(posedge clock)
        $fell(rst) |-> ladc_hpf_num0 == 16'h3955
            && ladc_hpf_num1[7:0] == 8'h2D;
    endproperty
    a_ladc_rst: assert property (p_ladc_rst) // R6
        else $error("high-pass reset defaults wrong");

    property p_rsvd_read;
        @(posedge clock) disable iff (rst)
        (rd_en && rsvd_hit) |=> rd_valid && rd_data == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) // R7
        else $error("reserved read not zero");

    property p_rsvd_write;
        @(posedge clock) disable iff (rst)
        (wr_en && rsvd_hit) |=> $stable(spatial_atten)
            && $stable(ladc_hpf_num0) && $stable(rdeemph_den1);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) // R7
        else $error("reserved write changed storage");

    property p_readback;
        @(posedge clock) disable iff (rst)
        (s_wr_atten_hi ##1 !(wr_en && addr == SPATIAL_ATTEN_HIGH)
            ##1 s_rd_atten_hi) |=> rd_data == $past(wr_data, 3);
    endproperty
    a_readback: assert property (p_readback) // R9
        else $error("read did not return last write");

    property p_read_valid;
        @(posedge clock) disable iff (rst)
        s_rd_mapped |=> rd_valid ##1 !rd_valid || $past(rd_en);
    endproperty
    a_read_valid: assert property (p_read_valid) // R9
        else $error("read answer timing wrong");

    property p_rd_idle;
        @(posedge clock) disable iff (rst)
        !rd_en |=> !rd_valid;
    endproperty
    a_rd_idle: assert property (p_rd_idle) // R9
        else $error("read answer without a read strobe");

    // Host may sample late, so the byte must hold
    property p_rd_hold;
        @(posedge clock) disable iff (rst)
        !rd_en |=> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold) // R9
        else $error("read data moved without a read");

    property p_wr_other;
        @(posedge clock) disable iff (rst)
        (wr_en && addr != SPATIAL_ATTEN_HIGH && addr != SPATIAL_ATTEN_LOW)
            |=> $stable(spatial_atten);
    endproperty
    a_wr_other: assert property (p_wr_other) // R9
        else $error("attenuation word changed by another write");

    property p_hi_pair;
        @(posedge clock) disable iff (rst)
        s_wr_atten_hi |=> $stable(spatial_atten[7:0]);
    endproperty
    a_hi_pair: assert property (p_hi_pair) // R3
        else $error("high byte write disturbed the low byte");

endmodule

// File: core/acr_pkg.sv
/*
 * Package for the filter coefficient register bank: offsets, reset
 * values and the reserved address range of the coefficient page.
 * Assumes a 7-bit register address within the already selected page.
 */
package acr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NREG = 12;
    localparam int AW   = 7;
    localparam int DW   = 8;

    // ------------------------------------------------------------------
    // Entry index of each byte register
    // ------------------------------------------------------------------
    localparam int I_RDE_N0_LO = 0;
    localparam int I_RDE_N1_HI = 1;
    localparam int I_RDE_N1_LO = 2;
    localparam int I_RDE_D1_HI = 3;
    localparam int I_RDE_D1_LO = 4;
    localparam int I_SPA_HI    = 5;
    localparam int I_SPA_LO    = 6;
    localparam int I_LHP_N0_HI = 7;
    localparam int I_LHP_N0_LO = 8;
    localparam int I_LHP_N1_HI = 9;
    localparam int I_LHP_N1_LO = 10;
    localparam int I_LHP_N1_LO2 = 11;

    // ------------------------------------------------------------------
    // Offsets
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] RDEEMPH_NUM0_LOW   = 7'h30;
    localparam logic [AW-1:0] RDEEMPH_NUM1_HIGH  = 7'h31;
    localparam logic [AW-1:0] RDEEMPH_NUM1_LOW   = 7'h32;
    localparam logic [AW-1:0] RDEEMPH_DEN1_HIGH  = 7'h33;
    localparam logic [AW-1:0] RDEEMPH_DEN1_LOW   = 7'h34;
    localparam logic [AW-1:0] SPATIAL_ATTEN_HIGH = 7'h35;
    localparam logic [AW-1:0] SPATIAL_ATTEN_LOW  = 7'h36;
    localparam logic [AW-1:0] RSVD_FIRST         = 7'h37;
    localparam logic [AW-1:0] RSVD_LAST          = 7'h40;
    localparam logic [AW-1:0] LADC_HPF_NUM0_HIGH = 7'h41;
    localparam logic [AW-1:0] LADC_HPF_NUM0_LOW  = 7'h42;
    localparam logic [AW-1:0] LADC_HPF_NUM1_HIGH = 7'h43;
    localparam logic [AW-1:0] LADC_HPF_NUM1_LOW  = 7'h44;

    localparam logic [AW-1:0] REG_OFS [NREG-1] = '{
        RDEEMPH_NUM0_LOW, RDEEMPH_NUM1_HIGH, RDEEMPH_NUM1_LOW,
        RDEEMPH_DEN1_HIGH, RDEEMPH_DEN1_LOW, SPATIAL_ATTEN_HIGH,
        SPATIAL_ATTEN_LOW, LADC_HPF_NUM0_HIGH, LADC_HPF_NUM0_LOW,
        LADC_HPF_NUM1_HIGH, LADC_HPF_NUM1_LOW};

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DW-1:0] RST_RDE_N0_LO = 8'h55;
    localparam logic [DW-1:0] RST_RDE_N1_HI = 8'hF3;
    localparam logic [DW-1:0] RST_RDE_N1_LO = 8'h00;
    localparam logic [DW-1:0] RST_RDE_D1_HI = 8'h53;
    localparam logic [DW-1:0] RST_RDE_D1_LO = 8'h7E;
    localparam logic [DW-1:0] RST_SPA_HI    = 8'h7F;
    localparam logic [DW-1:0] RST_SPA_LO    = 8'hFF;
    localparam logic [DW-1:0] RST_LHP_N0_HI = 8'h39;
    localparam logic [DW-1:0] RST_LHP_N0_LO = 8'h55;
    localparam logic [DW-1:0] RST_LHP_N1_HI = 8'h00;
    localparam logic [DW-1:0] RST_LHP_N1_LO = 8'h2D;
    localparam logic [DW-1:0] RSVD_VALUE    = 8'h00;

    localparam logic [DW-1:0] REG_RST [NREG-1] = '{
        RST_RDE_N0_LO, RST_RDE_N1_HI, RST_RDE_N1_LO, RST_RDE_D1_HI,
        RST_RDE_D1_LO, RST_SPA_HI, RST_SPA_LO, RST_LHP_N0_HI,
        RST_LHP_N0_LO, RST_LHP_N1_HI, RST_LHP_N1_LO};

endpackage

// File: tb/acr_host_model.sv
/*
 * Host model for the coefficient register port: byte writes and reads.
 * Assumes the bench clock and one request in flight at a time.
 */
`timescale 1ns/100ps
module acr_host (
    input  wire logic       clock,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [6:0] addr,
    output logic      [7:0] wr_data
);
    initial begin
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        addr    = 7'h00;
        wr_data = 8'h00;
    end

    // ------------------------------------------------------------------
    // Requests; idle bus shows the inverted address, and inverted data only after a write
    // ------------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a >= 7'h37 && a <= 7'h40) return;
        @(posedge clock);
        #1;
        wr_en   = 1'b1;
        addr    = a;
        wr_data = d;
        @(posedge clock);
        #1;
        wr_en   = 1'b0;
        addr    = ~a;
        wr_data = ~d;
    endtask

    // Fixed latency of one cycle, so no wait loop
    task automatic rd(input logic [6:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge clock);
        #1;
        rd_en = 1'b1;
        addr  = a;
        @(posedge clock);
        #1;
        rd_en = 1'b0;
        addr  = ~a;
        d     = rd_data;
        v     = rd_valid;
    endtask
endmodule

// File: tb/tb_acr_coeff_regs.sv
/*
 * Self-checking bench for the coefficient register bank.
 * Assumes the host model in acr_host_model.sv drives the register port.
 */
`timescale 1ns/100ps
module tb_acr_coeff_regs;
    import acr_pkg::*;
    typedef struct {
        logic [6:0] a;
        logic [7:0] r;
        logic [7:0] w;
    } acr_row_t;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic        wr_en, rd_en, rd_valid, v;
    logic [6:0]  addr;
    logic [7:0]  wr_data, rd_data, d, n0_low;
    logic [15:0] num1, den1, spa, hp0, hp1;
    int          bad_count = 0;
    int          cmp_count = 0;
    // Extreme bytes so whole words hit both ends of the signed span
    acr_row_t rows [11] = '{
        '{7'h30, 8'h55, 8'hA5}, '{7'h31, 8'hF3, 8'h80},
        '{7'h32, 8'h00, 8'h00}, '{7'h33, 8'h53, 8'h7F},
        '{7'h34, 8'h7E, 8'hFF}, '{7'h35, 8'h7F, 8'h80},
        '{7'h36, 8'hFF, 8'h01}, '{7'h41, 8'h39, 8'hFE},
        '{7'h42, 8'h55, 8'h12}, '{7'h43, 8'h00, 8'hC3},
        '{7'h44, 8'h2D, 8'h3C}};

    always #2.5 clock = ~clock;

    acr_host host (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));

    acr_coeff_regs DUT (.clock(clock), .rst(rst), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .rdeemph_num0_low(n0_low),
        .rdeemph_num1(num1), .rdeemph_den1(den1), .spatial_atten(spa),
        .ladc_hpf_num0(hp0), .ladc_hpf_num1(hp1));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run is about 94 cycles; generous margin
    initial begin
        #5000;
        bad_count++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        foreach (rows[i]) begin
            host.rd(rows[i].a, d, v);
            chk({8'h00, d}, {8'h00, rows[i].r});
            chk({15'h0000, v}, 16'h0001);
            host.wr(rows[i].a, rows[i].w);
            host.rd(rows[i].a, d, v);
            chk({8'h00, d}, {8'h00, rows[i].w});
        end
        chk({8'h00, n0_low}, 16'h00A5);
        chk(num1, 16'h8000);
        chk(den1, 16'h7FFF);
        chk(spa, 16'h8001);
        chk(hp0, 16'hFE12);
        chk(hp1, 16'hC33C);
        for (int a = 'h37; a <= 'h40; a++) begin
            host.rd(7'(a), d, v);
            chk({8'h00, d}, 16'h0000);
        end
        // Mid-run reset must act without waiting for an edge
        @(posedge clock);
        #1;
        rst = 1'b1;
        #1;
        chk(spa, 16'h7FFF);
        chk(hp0, 16'h3955);
        chk(den1, 16'h537E);
        chk({8'h00, n0_low}, 16'h0055);
        @(posedge clock);
        #1;
        rst = 1'b0;
        host.rd(7'h31, d, v);
        chk({8'h00, d}, 16'h00F3);
        end_of_test();
    end
endmodule
